// *** hw/ucs_pkg.sv ***
// ucs_pkg: constants and carrier types for the channel status flags
// assumes one clock domain and register access over AXI4-Lite
package ucs_pkg;
   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int unsigned AXI_AW = 8;
   localparam int unsigned AXI_DW = 32;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_MODE   = 4'h0;
   localparam logic [3:0] IDX_STATUS = 4'h1;
   localparam logic [3:0] IDX_CMD    = 4'h2;
   localparam logic [3:0] IDX_DATA   = 4'h3;
   localparam logic [3:0] IDX_IMR    = 4'h4;
   localparam logic [3:0] IDX_ISR    = 4'h5;
   localparam logic [3:0] IDX_LAST   = IDX_ISR;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // field positions and codes
   // ---------------------------------------------------------------
   localparam int unsigned CMD_LSB     = 4;
   localparam int unsigned TXC_LSB     = 2;
   localparam int unsigned MODE_COMPAT = 3;
   localparam logic [3:0] CMD_RX_RESET  = 4'h2;
   localparam logic [3:0] CMD_TX_RESET  = 4'h3;
   localparam logic [3:0] CMD_ERR_RESET = 4'h4;
   localparam logic [1:0] TXC_ENABLE  = 2'h1;
   localparam logic [1:0] TXC_DISABLE = 2'h2;
   localparam int unsigned ST_BRK   = 7;
   localparam int unsigned ST_FE    = 6;
   localparam int unsigned ST_PE    = 5;
   localparam int unsigned ST_OVR   = 4;
   localparam int unsigned ST_EMT   = 3;
   localparam int unsigned ST_RDY   = 2;
   localparam int unsigned ST_FULL  = 1;
   localparam int unsigned ST_RXRDY = 0;
   localparam int unsigned EV_W   = 3;
   localparam int unsigned EV_OVR = 0;
   localparam int unsigned EV_EMT = 1;
   localparam int unsigned EV_RDY = 2;
   localparam logic [4:0] LVL_NORM   = 5'h10;
   localparam logic [4:0] LVL_COMPAT = 5'h08;

   // ---------------------------------------------------------------
   // carriers and state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } ucs_char_s;

   typedef struct packed {
      logic       wr;
      logic [3:0] widx;
      logic [7:0] wdata;
      logic       rd;
      logic [3:0] ridx;
   } ucs_req_s;

   typedef struct packed {
      logic       aw_v;
      logic       aw_ok;
      logic [3:0] awidx;
      logic       w_v;
      logic       wstb;
      logic [7:0] wdata;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } ucs_axi_s;

   typedef struct packed {
      logic [15:0][10:0] rxf;
      logic [3:0]        rx_rp;
      logic [3:0]        rx_wp;
      logic [4:0]        rx_cnt;
      logic              hold_v;
      ucs_char_s         hold;
      logic              ovr;
      logic [15:0][7:0]  txf;
      logic [3:0]        tx_rp;
      logic [3:0]        tx_wp;
      logic [4:0]        tx_cnt;
      logic              tx_on;
      logic              tx_pend;
      logic              tx_emt;
      logic              tx_rdy;
      logic              compat;
      logic [EV_W-1:0]   imr;
      logic [EV_W-1:0]   interrupt_status;
   } ucs_state_s;

   localparam ucs_axi_s   AXI_RST   = '0;
   localparam ucs_state_s STATE_RST = '0;

   function automatic logic ucs_addr_ok(input logic [AXI_AW-1:0] a);
      return (a[1:0] == 2'h0) && (a[AXI_AW-1:2] <= {2'h0, IDX_LAST});
   endfunction
endpackage

// *** hw/ucs_axil_slave.sv ***
// ucs_axil_slave: AXI4-Lite slave turning bus beats into register strobes
// assumes the register file answers rd_data combinationally from req.ridx
`timescale 1ns/1ns
module ucs_axil_slave (
   input  logic                         clk,
   input  logic                         resetn,
   input  logic [ucs_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  logic                         s_axi_awvalid,
   output logic                         s_axi_awready,
   input  logic [ucs_pkg::AXI_DW-1:0]   s_axi_wdata,
   input  logic [3:0]                   s_axi_wstrb,
   input  logic                         s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  logic                         s_axi_bready,
   input  logic [ucs_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  logic                         s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [ucs_pkg::AXI_DW-1:0]   s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  logic                         s_axi_rready,
   output ucs_pkg::ucs_req_s            req,
   input  logic [7:0]                   rd_data
);
   import ucs_pkg::*;

   ucs_axi_s ax_q;
   ucs_axi_s ax_d;
   logic     wr_fire;
   logic     rd_take;
   logic     ar_ok;

   assign wr_fire = ax_q.aw_v && ax_q.w_v && !ax_q.bvalid;
   assign rd_take = s_axi_arvalid && !ax_q.rvalid;
   assign ar_ok   = ucs_addr_ok(s_axi_araddr);

   assign s_axi_awready = !ax_q.aw_v;
   assign s_axi_wready  = !ax_q.w_v;
   assign s_axi_arready = !ax_q.rvalid;
   assign s_axi_bvalid  = ax_q.bvalid;
   assign s_axi_bresp   = ax_q.bresp;
   assign s_axi_rvalid  = ax_q.rvalid;
   assign s_axi_rresp   = ax_q.rresp;
   assign s_axi_rdata   = {{(AXI_DW-8){1'b0}}, ax_q.rdata};

   // only the low byte lane carries register bits
   assign req.wr    = wr_fire && ax_q.aw_ok && ax_q.wstb;
   assign req.widx  = ax_q.awidx;
   assign req.wdata = ax_q.wdata;
   assign req.rd    = rd_take && ar_ok;
   assign req.ridx  = s_axi_araddr[5:2];

   always_comb begin
      ax_d = ax_q;
      if (s_axi_awvalid && !ax_q.aw_v) begin
         ax_d.aw_v  = 1'b1;
         ax_d.aw_ok = ucs_addr_ok(s_axi_awaddr);
         ax_d.awidx = s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && !ax_q.w_v) begin
         ax_d.w_v   = 1'b1;
         ax_d.wstb  = s_axi_wstrb[0];
         ax_d.wdata = s_axi_wdata[7:0];
      end
      if (ax_q.bvalid && s_axi_bready) begin
         ax_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         ax_d.aw_v   = 1'b0;
         ax_d.w_v    = 1'b0;
         ax_d.bvalid = 1'b1;
         ax_d.bresp  = ax_q.aw_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (ax_q.rvalid && s_axi_rready) begin
         ax_d.rvalid = 1'b0;
      end
      if (rd_take) begin
         ax_d.rvalid = 1'b1;
         ax_d.rresp  = ar_ok ? RESP_OKAY : RESP_SLVERR;
         ax_d.rdata  = ar_ok ? rd_data : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ax_q <= AXI_RST;
      end else begin
         ax_q <= ax_d;
      end
   end
endmodule // ucs_axil_slave

// *** hw/ucs_status_flags.sv ***
// ucs_status_flags: overrun, transmitter empty and ready flags of one
// channel, with receive and transmit character queues
// assumes a serial front end that delivers received characters as
// one-cycle pulses and a serializer that takes characters by handshake
//
// Overview of operation
// - overrun sets when a char arrives, queue full, holding register occupied
// - on overrun the held character and its status bits are thrown away
// - overrun stays set until error reset; queue reads leave it alone
// - empty flag set on underrun, with ready flag also set
// - enabling a disabled or reset transmitter sets empty and ready
// - empty set after last stop bit when no character waits
// - empty cleared by load, executed pending disable, reset, underrun disable
// - ready means room in transmit queue; cleared when a load fills it
// - ready set when a character moves into the shift register, unless a disable is pending
// - ready cleared on disable, set on first enable
// - receive queue full at eight entries in compat mode, else sixteen
// - command code 0x4 and receiver reset clear the overrun flag
`timescale 1ns/1ns
module ucs_status_flags (
   input  logic                         clk,
   input  logic                         resetn,
   input  logic [ucs_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  logic                         s_axi_awvalid,
   output logic                         s_axi_awready,
   input  logic [ucs_pkg::AXI_DW-1:0]   s_axi_wdata,
   input  logic [3:0]                   s_axi_wstrb,
   input  logic                         s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  logic                         s_axi_bready,
   input  logic [ucs_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  logic                         s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [ucs_pkg::AXI_DW-1:0]   s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  logic                         s_axi_rready,
   input  ucs_pkg::ucs_char_s           rx_char,
   input  logic                         rx_char_valid,
   output logic [7:0]                   tx_char,
   output logic                         tx_char_valid,
   input  logic                         tx_char_ready,
   input  logic                         tx_stop_sent,
   output logic                         irq
);
   import ucs_pkg::*;

   // ---------------------------------------------------------------
   // register strobes
   // ---------------------------------------------------------------
   ucs_req_s   req;
   logic [7:0] rd_data;

   ucs_axil_slave u_bus (
      .clk           (clk),
      .resetn        (resetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .req           (req),
      .rd_data       (rd_data)
   );

   ucs_state_s    st_q;
   ucs_state_s    st_d;
   ucs_char_s     top;
   logic [4:0]    lvl;
   logic          cmd_wr;
   logic [3:0]    cmd_code;
   logic [1:0]    txc;
   logic          err_clr;
   logic          rx_rst;
   logic          tx_rst;
   logic          tx_en_cmd;
   logic          tx_dis_cmd;
   logic          pop;
   logic          load;
   logic          xfer;
   logic          rx_rdy;
   logic [7:0]    status;

   assign lvl        = st_q.compat ? LVL_COMPAT : LVL_NORM;
   assign cmd_wr     = req.wr && (req.widx == IDX_CMD);
   assign cmd_code   = req.wdata[CMD_LSB +: 4];
   assign txc        = req.wdata[TXC_LSB +: 2];
   assign rx_rst     = cmd_wr && (cmd_code == CMD_RX_RESET);
   assign err_clr    = cmd_wr && ((cmd_code == CMD_ERR_RESET)
                                  || rx_rst);
   assign tx_rst     = cmd_wr && (cmd_code == CMD_TX_RESET);
   assign tx_en_cmd  = cmd_wr && !tx_rst && (txc == TXC_ENABLE);
   assign tx_dis_cmd = cmd_wr && !tx_rst && (txc == TXC_DISABLE);
   assign pop        = req.rd && (req.ridx == IDX_DATA)
                       && (st_q.rx_cnt != 5'h00);
   // writes while not ready are lost, as the host was told
   assign load       = req.wr && (req.widx == IDX_DATA)
                       && st_q.tx_rdy && !tx_rst;
   assign xfer       = tx_char_valid && tx_char_ready;
   assign rx_rdy     = st_q.rx_cnt != 5'h00;
   assign top        = st_q.rxf[st_q.rx_rp];

   assign tx_char       = st_q.txf[st_q.tx_rp];
   assign tx_char_valid = st_q.tx_on && (st_q.tx_cnt != 5'h00);
   assign irq           = |(st_q.interrupt_status & st_q.imr);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [EV_W-1:0] ev;
      logic [EV_W-1:0] isr_clr;
      ev      = '0;
      isr_clr = '0;
      st_d    = st_q;
      // receive side: resets first so that same-cycle events survive
      if (rx_rst) begin
         st_d.rx_rp  = 4'h0;
         st_d.rx_wp  = 4'h0;
         st_d.rx_cnt = 5'h00;
         st_d.hold_v = 1'b0;
      end
      if (err_clr) begin
         st_d.ovr = 1'b0;
      end
      if (pop && !rx_rst) begin
         st_d.rx_rp  = st_d.rx_rp + 4'h1;
         st_d.rx_cnt = st_d.rx_cnt - 5'h01;
      end
      if (st_d.hold_v && (st_d.rx_cnt < lvl)) begin
         st_d.rxf[st_d.rx_wp] = st_d.hold;
         st_d.rx_wp  = st_d.rx_wp + 4'h1;
         st_d.rx_cnt = st_d.rx_cnt + 5'h01;
         st_d.hold_v = 1'b0;
      end
      if (rx_char_valid) begin
         if (!st_d.hold_v && (st_d.rx_cnt < lvl)) begin
            st_d.rxf[st_d.rx_wp] = rx_char;
            st_d.rx_wp  = st_d.rx_wp + 4'h1;
            st_d.rx_cnt = st_d.rx_cnt + 5'h01;
         end else begin
            if (st_d.hold_v) begin
               st_d.ovr   = 1'b1;
               ev[EV_OVR] = 1'b1;
            end
            // new character overwrites the held one with its status
            st_d.hold   = rx_char;
            st_d.hold_v = 1'b1;
         end
      end
      // transmit side
      if (tx_rst) begin
         st_d.tx_rp   = 4'h0;
         st_d.tx_wp   = 4'h0;
         st_d.tx_cnt  = 5'h00;
         st_d.tx_on   = 1'b0;
         st_d.tx_pend = 1'b0;
         st_d.tx_emt  = 1'b0;
      end
      if (tx_dis_cmd && st_d.tx_on) begin
         if (st_d.tx_emt) begin
            st_d.tx_on  = 1'b0;
            st_d.tx_emt = 1'b0;
         end else begin
            // queued characters still go out before shutting down
            st_d.tx_pend = 1'b1;
         end
      end
      if (tx_en_cmd) begin
         if (!st_d.tx_on) begin
            st_d.tx_on  = 1'b1;
            st_d.tx_emt = 1'b1;
         end
         st_d.tx_pend = 1'b0;
      end
      if (load) begin
         st_d.txf[st_d.tx_wp] = req.wdata;
         st_d.tx_wp  = st_d.tx_wp + 4'h1;
         st_d.tx_cnt = st_d.tx_cnt + 5'h01;
         st_d.tx_emt = 1'b0;
      end
      if (xfer && !tx_rst) begin
         st_d.tx_rp  = st_d.tx_rp + 4'h1;
         st_d.tx_cnt = st_d.tx_cnt - 5'h01;
      end
      if (tx_stop_sent && !xfer && st_d.tx_on
          && (st_d.tx_cnt == 5'h00)) begin
         if (st_d.tx_pend) begin
            st_d.tx_on   = 1'b0;
            st_d.tx_pend = 1'b0;
            st_d.tx_emt  = 1'b0;
         end else begin
            st_d.tx_emt = 1'b1;
         end
      end
      st_d.tx_rdy = st_d.tx_on && !st_d.tx_pend
                    && (st_d.tx_cnt < lvl);
      ev[EV_EMT] = st_d.tx_emt && !st_q.tx_emt;
      ev[EV_RDY] = st_d.tx_rdy && !st_q.tx_rdy;
      // control registers; a set in the clearing cycle wins
      if (req.wr && (req.widx == IDX_MODE)) begin
         st_d.compat = req.wdata[MODE_COMPAT];
      end
      if (req.wr && (req.widx == IDX_IMR)) begin
         st_d.imr = req.wdata[EV_W-1:0];
      end
      if (req.wr && (req.widx == IDX_ISR)) begin
         isr_clr = req.wdata[EV_W-1:0];
      end
      st_d.interrupt_status = (st_q.interrupt_status & ~isr_clr) | ev;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // read mux; only a data read pops, status reads are pure
   // ---------------------------------------------------------------
   always_comb begin
      status           = 8'h00;
      status[ST_BRK]   = rx_rdy && top.brk;
      status[ST_FE]    = rx_rdy && top.fe;
      status[ST_PE]    = rx_rdy && top.pe;
      status[ST_OVR]   = st_q.ovr;
      status[ST_EMT]   = st_q.tx_emt;
      status[ST_RDY]   = st_q.tx_rdy;
      status[ST_FULL]  = st_q.rx_cnt == lvl;
      status[ST_RXRDY] = rx_rdy;
      case (req.ridx)
         IDX_MODE: begin
            rd_data              = 8'h00;
            rd_data[MODE_COMPAT] = st_q.compat;
         end
         IDX_STATUS: rd_data = status;
         IDX_DATA:   rd_data = rx_rdy ? top.data : 8'h00;
         IDX_IMR:    rd_data = {5'h00, st_q.imr};
         IDX_ISR:    rd_data = {5'h00, st_q.interrupt_status};
         default:    rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_overrun;
      rx_char_valid && st_q.hold_v && (st_q.rx_cnt == lvl)
      && !pop && !rx_rst && !err_clr;
   endsequence

   sequence s_fill_then_one;
      (rx_char_valid && !st_q.hold_v && (st_q.rx_cnt == lvl - 5'h01)
       && !pop && !req.wr) ##1
      (rx_char_valid && !pop && !req.wr);
   endsequence

   property p_ovr_set;
      s_overrun |=> st_q.ovr && st_q.interrupt_status[EV_OVR];
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("overrun not flagged");

   property p_ovr_drop;
      s_overrun |=> (st_q.hold == $past(rx_char))
                    && (st_q.rx_cnt == $past(st_q.rx_cnt));
   endproperty
   a_ovr_drop: assert property (p_ovr_drop)
      else $error("held character not replaced on overrun");

   property p_ovr_sticky;
      st_q.ovr && !err_clr |=> st_q.ovr;
   endproperty
   a_ovr_sticky: assert property (p_ovr_sticky)
      else $error("overrun flag dropped without error reset");

   property p_err_clr;
      err_clr && !rx_char_valid |=> !st_q.ovr;
   endproperty
   a_err_clr: assert property (p_err_clr)
      else $error("error reset left overrun set");

   property p_emt_rdy;
      st_q.tx_emt |-> st_q.tx_rdy && (st_q.tx_cnt == 5'h00);
   endproperty
   a_emt_rdy: assert property (p_emt_rdy)
      else $error("empty flag without ready or with queued data");

   property p_enable;
      tx_en_cmd && !st_q.tx_on |=> st_q.tx_emt && st_q.tx_rdy;
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable did not set empty and ready");

   property p_last_stop;
      tx_stop_sent && !xfer && (st_q.tx_cnt == 5'h00) && !req.wr
      && st_q.tx_on && !st_q.tx_pend |=> st_q.tx_emt;
   endproperty
   a_last_stop: assert property (p_last_stop)
      else $error("empty not set after last stop bit");

   property p_load_clr;
      load |=> !st_q.tx_emt ##1 st_q.tx_cnt != 5'h00 || !st_q.tx_emt
               || $past(xfer);
   endproperty
   a_load_clr: assert property (p_load_clr)
      else $error("load did not clear empty flag");

   property p_full_clr;
      load && !xfer && (st_q.tx_cnt == lvl - 5'h01) |=> !st_q.tx_rdy;
   endproperty
   a_full_clr: assert property (p_full_clr)
      else $error("ready stayed set with full transmit queue");

   property p_xfer_set;
      xfer && st_q.tx_on && !st_q.tx_pend && !req.wr |=> st_q.tx_rdy;
   endproperty
   a_xfer_set: assert property (p_xfer_set)
      else $error("transfer to shifter did not set ready");

   property p_disable;
      tx_dis_cmd |=> !st_q.tx_rdy;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable left ready set");

   property p_rx_depth;
      s_fill_then_one |=> st_q.hold_v && (st_q.rx_cnt == $past(lvl));
   endproperty
   a_rx_depth: assert property (p_rx_depth)
      else $error("receive queue full point wrong");
endmodule // ucs_status_flags

// *** testbench/ucs_ser_model.sv ***
// ucs_ser_model: serializer standing behind the transmit queue
// assumes the flags block hands over characters by valid/ready
`timescale 1ns/1ns
module ucs_ser_model #(parameter int DLY = 5) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic stall,
   input  wire logic tx_char_valid,
   output logic      tx_char_ready,
   output logic      tx_stop_sent
);
   int cnt_q;
   // busy while shifting, so the next char must wait in the queue
   assign tx_char_ready = (cnt_q == 0) && !stall;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 0;
         tx_stop_sent <= 1'b0;
      end else begin
         tx_stop_sent <= (cnt_q == 1);
         if (tx_char_valid && tx_char_ready)
            cnt_q <= DLY;
         else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
      end
   end
endmodule // ucs_ser_model

// *** testbench/tb.sv ***
// tb: random and corner traffic for the channel status flags
// assumes the register map and handshakes of the designer's note
`timescale 1ns/1ns
module tb;
   import ucs_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [7:0] A_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [7:0] A_ST   = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [7:0] A_CMD  = {2'h0, IDX_CMD, 2'h0};
   localparam logic [7:0] A_DATA = {2'h0, IDX_DATA, 2'h0};
   localparam logic [7:0] A_IMR  = {2'h0, IDX_IMR, 2'h0};
   localparam logic [7:0] A_ISR  = {2'h0, IDX_ISR, 2'h0};
   logic        clk = 1'b0, resetn = 1'b0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, tx_char;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, rx_char_valid = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, tx_char_valid, tx_char_ready, tx_stop_sent;
   logic        irq, stall = 1'b0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, wresp;
   ucs_char_s   rx_char = '0;
   int          errors = 0, checks_done = 0;
   logic [7:0]  txq[$];
   always #10 clk = ~clk;
   ucs_status_flags dut (.*);
   ucs_ser_model #(.DLY(5)) ser (.clk, .resetn, .stall, .tx_char_valid,
      .tx_char_ready, .tx_stop_sent);
   always @(posedge clk) if (tx_char_valid && tx_char_ready)
      txq.push_back(tx_char);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic hang();
      errors++;
      $display("CHECK FAILED wait exp done got stuck");
      close_out();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            wresp = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
      if (n == 50) hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) hang();
   endtask
   task automatic st(input logic [7:0] e, input string nm);
      logic [31:0] d;
      logic [1:0]  r;
      rd(A_ST, d, r);
      chk(nm, {24'h0, e}, d);
   endtask
   function automatic logic [7:0] st_of(ucs_char_s h, logic o, f);
      return {h.brk, h.fe, h.pe, o, 2'b00, f, f};
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          dep, n;
      ucs_char_s   rxs[18];
      logic [7:0]  txs[16];
      void'($urandom(32'h32A0B3B3));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      st(8'h00, "status after reset");
      rd(8'h40, d, r);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      // index bits alias the mode register; a refused write must not land
      wr(8'h40, 8'h08);
      chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
      rd(A_MODE, d, r);
      chk("mode after bad wr", 32'h0, d);
      wr(A_IMR, 8'h01);
      chk("wr resp", {30'h0, RESP_OKAY}, {30'h0, wresp});
      for (int m = 0; m < 2; m++) begin
         dep = m ? 8 : 16;
         wr(A_MODE, m ? 8'h08 : 8'h00);
         stall <= 1'b1;
         txq.delete();
         wr(A_CMD, 8'h04);
         st(8'h0C, "tx enabled");
         for (n = 0; n < dep; n++) begin
            txs[n] = 8'($urandom);
            wr(A_DATA, txs[n]);
         end
         st(8'h00, "tx queue full");
         wr(A_DATA, 8'hA5);
         stall <= 1'b0;
         for (n = 0; n < 50 && txq.size() == 0; n++) @(posedge clk);
         if (n == 50) hang();
         st(8'h04, "tx slot freed");
         for (n = 0; n < 200; n++) begin
            rd(A_ST, d, r);
            if (d[ST_EMT] === 1'b1) break;
         end
         if (n == 200) hang();
         chk("tx count", dep, txq.size());
         for (n = 0; n < dep; n++) chk("tx char", txs[n], txq[n]);
         st(8'h0C, "tx underrun");
         rd(A_ISR, d, r);
         chk("isr tx events", 32'h6, d);
         wr(A_CMD, m ? 8'h30 : 8'h08);
         st(8'h00, "tx disabled");
         // queue, holding slot, then one more char to overrun
         for (n = 0; n < dep + 2; n++) begin
            rxs[n] = 11'($urandom);
            @(posedge clk);
            rx_char <= rxs[n];
            rx_char_valid <= 1'b1;
         end
         @(posedge clk);
         rx_char_valid <= 1'b0;
         st(st_of(rxs[0], 1'b1, 1'b1), "overrun");
         st(st_of(rxs[0], 1'b1, 1'b1), "status reread");
         chk("irq raised", 32'h1, {31'h0, irq});
         wr(A_IMR, 8'h00);
         chk("irq masked", 32'h0, {31'h0, irq});
         wr(A_IMR, 8'h01);
         for (n = 0; n <= dep; n++) begin
            rd(A_DATA, d, r);
            chk("rx char", n < dep ? rxs[n].data : rxs[dep+1].data, d);
         end
         st(st_of('0, 1'b1, 1'b0), "overrun sticky");
         wr(A_CMD, m ? 8'h20 : 8'h40);
         st(8'h00, "error reset");
         wr(A_ISR, 8'h07);
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
      // pending disable: queued char still goes out, then tx turns off
      wr(A_CMD, 8'h04);
      st(8'h0C, "enable after tx reset");
      stall <= 1'b1;
      txq.delete();
      wr(A_DATA, 8'h5A);
      wr(A_CMD, 8'h08);
      st(8'h00, "disable pending");
      stall <= 1'b0;
      for (n = 0; n < 50 && txq.size() == 0; n++) @(posedge clk);
      if (n == 50) hang();
      repeat (10) @(posedge clk);
      chk("tx pending char", 32'h5A, {24'h0, txq[0]});
      st(8'h00, "pending disable done");
      wr(A_CMD, 8'h04);
      st(8'h0C, "enable after disable");
      close_out();
   end
endmodule // tb
